// ---- src/mb_motion_slave.sv ----
/*
 Motion slave end: parses write-multiple-register queries, loads the
 motion command registers, starts moves and echoes a short response.
 Assumes the master sends one character per valid cycle and waits for
 the response before the next query (characters during a response are dropped).
*/
// Functional notes
// - Start address four hex chars, target first
// - Count writes exactly that contiguous register range
// - Byte count must equal twice register count
// - 32-bit values: upper word at lower address
// - Target position in hundredths of millimetre
// - Positioning band in hundredths of millimetre
// - Speed in hundredths of millimetre per second
// - Acceleration register in hundredths of G
// - Check value sent and verified before acting
// - Response echoes header fields with new check
// - Full block write starts a move
// - Speed write during move changes speed only
`timescale 1ns/1ns
module mb_motion_slave
   import mb_motion_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   mb_link_if.slave LINK,
   input wire logic [7:0] AXIS,
   input wire logic MOVING,
   output logic [31:0] TARGET_POSITION,
   output logic [31:0] IN_POSITION_BAND,
   output logic [31:0] TRAVEL_SPEED,
   output logic [15:0] ACCEL_DECEL,
   output logic MOVE_START,
   output logic SPEED_UPDATE,
   output logic FRAME_ERROR
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_HI = 5'b00010,
      ST_LO = 5'b00100,
      ST_LF = 5'b01000,
      ST_RESP = 5'b10000
   } slave_state_type;

   slave_state_type state;
   logic [3:0] hi_nib;
   logic [5:0] bidx;
   logic [7:0] sum;
   logic [7:0] slave;
   logic [7:0] func;
   logic [15:0] start;
   logic [15:0] count;
   logic [7:0] bcount;
   logic [7:0] stage [STAGE_BYTES];
   logic [15:0] regs [NUM_REGS];
   logic [4:0] tx_pos;
   logic [4:0] nib;
   logic [7:0] rx_byte;
   logic [15:0] s_off;
   logic [2:0] s_idx;
   logic [5:0] exp_len;
   logic range_ok;
   logic frame_ok;
   logic commit;
   logic char_bad;
   logic full_write;
   logic speed_hit;
   logic [7:0] rsp [RESP_BYTES];
   logic [7:0] rsp_byte;
   logic [7:0] next_char;

   assign nib = hex_decode(LINK.q_char);
   assign rx_byte = {hi_nib, nib[3:0]};
   assign s_off = start - REG_TARGET_POSITION;
   assign s_idx = s_off[2:0];
   assign exp_len = HDR_BYTES + {1'b0, count[3:0], 1'b0} + 6'h01;
   // Range checks; addresses outside the block are refused
   assign range_ok = (start >= REG_TARGET_POSITION) && (s_off < 16'(NUM_REGS))
      && (count != 16'h0000) && ((s_off + count) <= 16'(NUM_REGS));
   // Byte count, length and check value all verified
   assign frame_ok = (slave == 8'(AXIS + AXIS_ADDR_OFFSET)) && (func == FUNC_WRITE_MULTI)
      && range_ok && (bcount == 8'({count[6:0], 1'b0})) && (bidx == exp_len)
      && (sum == 8'h00);
   assign commit = (state == ST_LF) && LINK.q_valid && (LINK.q_char == CH_LF) && frame_ok;
   // A move only on a write that covers the whole block
   assign full_write = (s_idx == IDX_TARGET) && (count[3:0] == REGS_FULL);
   // Speed pair inside the written range
   assign speed_hit = (s_idx <= IDX_SPEED) && ((4'(s_idx) + count[3:0]) >= SPEED_END);
   // Bad character: not hex where hex is due, or junk before LF
   assign char_bad = LINK.q_valid && (LINK.q_char != CH_COLON) && (
      ((state == ST_HI) && !nib[4] && (LINK.q_char != CH_CR)) ||
      ((state == ST_LO) && !nib[4]) ||
      ((state == ST_LF) && (LINK.q_char != CH_LF)));

   // Frame state; a colon restarts the parse from ST_IDLE, ST_HI or ST_LO, while in ST_LF it drops the frame
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_IDLE;
         tx_pos <= 5'h00;
      end else begin
         unique case (state)
            ST_IDLE, ST_HI, ST_LO: begin
               if (LINK.q_valid) begin
                  if (LINK.q_char == CH_COLON) begin
                     state <= ST_HI;
                  end else if (state == ST_HI && LINK.q_char == CH_CR) begin
                     state <= ST_LF;
                  end else if (state != ST_IDLE && char_bad) begin
                     state <= ST_IDLE;
                  end else if (state == ST_HI) begin
                     state <= ST_LO;
                  end else if (state == ST_LO) begin
                     state <= ST_HI;
                  end
               end
            end
            ST_LF: begin
               if (LINK.q_valid) begin
                  tx_pos <= 5'h00;
                  state <= commit ? ST_RESP : ST_IDLE;
               end
            end
            ST_RESP: begin
               // Link is ignored here so the echoed fields stay put
               tx_pos <= 5'(tx_pos + 5'h01);
               if (tx_pos == RESP_LF_POS) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Byte assembly, running check sum and header capture
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         hi_nib <= 4'h0;
         bidx <= 6'h00;
         sum <= 8'h00;
         slave <= 8'h00;
         func <= 8'h00;
         start <= 16'h0000;
         count <= 16'h0000;
         bcount <= 8'h00;
      end else if (LINK.q_valid && state != ST_RESP) begin
         if (LINK.q_char == CH_COLON) begin
            bidx <= 6'h00;
            sum <= 8'h00;
         end else if (state == ST_HI && nib[4]) begin
            hi_nib <= nib[3:0];
         end else if (state == ST_LO && nib[4]) begin
            sum <= 8'(sum + rx_byte);
            bidx <= (bidx == LEN_SAT) ? bidx : 6'(bidx + 6'h01);
            unique case (bidx)
               6'h00: slave <= rx_byte;
               6'h01: func <= rx_byte;
               6'h02: start[15:8] <= rx_byte;
               6'h03: start[7:0] <= rx_byte;
               6'h04: count[15:8] <= rx_byte;
               6'h05: count[7:0] <= rx_byte;
               6'h06: bcount <= rx_byte;
               default: ;
            endcase
         end
      end
   end

   // Data bytes staged until the check value has been verified
   always_ff @(posedge CLK) begin
      if (LINK.q_valid && state == ST_LO && nib[4] && bidx >= HDR_BYTES
          && bidx < 6'(HDR_BYTES + 6'(STAGE_BYTES))) begin
         stage[4'(bidx - HDR_BYTES)] <= rx_byte;
      end
   end

   // Commit only the addressed registers, high byte first in each word
   for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      logic [2:0] k;
      logic hit;
      assign k = 3'(3'(i) - s_idx);
      assign hit = (3'(i) >= s_idx) && (4'(k) < count[3:0]);
      always_ff @(posedge CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            regs[i] <= REG_RESET;
         end else if (commit && hit) begin
            regs[i] <= {stage[{k, 1'b0}], stage[{k, 1'b1}]};
         end
      end
   end

   // Upper word sits at the lower address
   assign TARGET_POSITION = {regs[IDX_TARGET], regs[IDX_TARGET + 3'h1]};
   assign IN_POSITION_BAND = {regs[IDX_BAND], regs[IDX_BAND + 3'h1]};
   assign TRAVEL_SPEED = {regs[IDX_SPEED], regs[IDX_SPEED + 3'h1]};
   assign ACCEL_DECEL = regs[IDX_ACCEL];

   // Motion pulses, one cycle after the LF that commits the values; error pulse one cycle after a bad character or refused LF
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         MOVE_START <= 1'b0;
         SPEED_UPDATE <= 1'b0;
         FRAME_ERROR <= 1'b0;
      end else begin
         MOVE_START <= commit && full_write;
         // Speed change keeps the move going, no restart
         SPEED_UPDATE <= commit && !full_write && speed_hit && MOVING;
         // Frames for other slaves are dropped without an error unless a character is bad
         FRAME_ERROR <= char_bad || ((state == ST_LF) && LINK.q_valid
            && (LINK.q_char == CH_LF) && !frame_ok
            && (slave == 8'(AXIS + AXIS_ADDR_OFFSET)));
      end
   end

   // Echoed response bytes with a fresh check value
   assign rsp[0] = slave;
   assign rsp[1] = func;
   assign rsp[2] = start[15:8];
   assign rsp[3] = start[7:0];
   assign rsp[4] = count[15:8];
   assign rsp[5] = count[7:0];
   assign rsp[6] = 8'(8'h00 - 8'(slave + func + start[15:8] + start[7:0]
      + count[15:8] + count[7:0]));

   always_comb begin
      rsp_byte = rsp[3'(5'(tx_pos - 5'h01) >> 1)];
      if (tx_pos == 5'h00) begin
         next_char = CH_COLON;
      end else if (tx_pos == RESP_CR_POS) begin
         next_char = CH_CR;
      end else if (tx_pos == RESP_LF_POS) begin
         next_char = CH_LF;
      end else begin
         next_char = hex_encode(tx_pos[0] ? rsp_byte[7:4] : rsp_byte[3:0]);
      end
   end

   // Response characters, one per cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         LINK.r_valid <= 1'b0;
         LINK.r_char <= 8'h00;
      end else begin
         LINK.r_valid <= (state == ST_RESP);
         LINK.r_char <= (state == ST_RESP) ? next_char : 8'h00;
      end
   end
endmodule

// ---- src/mb_motion_pkg.sv ----
/*
 Shared constants for the ASCII write-multiple-register link that loads
 the motion command registers: characters, field layout, register
 indices, host register map and timing.
 Assumes both ends exchange one ASCII character per clock on a valid strobe.
*/
package mb_motion_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Frame characters
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_DIGIT_0 = 8'h30;
   localparam logic [7:0] CH_DIGIT_9 = 8'h39;
   localparam logic [7:0] CH_UPPER_A = 8'h41;
   localparam logic [7:0] CH_UPPER_F = 8'h46;
   localparam logic [3:0] HEX_ALPHA_ADJ = 4'h9;
   localparam logic [3:0] HEX_TEN = 4'ha;
   localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] AXIS_ADDR_OFFSET = 8'h01;
   // Motion command block, one 16-bit word per register
   localparam logic [15:0] REG_TARGET_POSITION = 16'h9900;
   localparam logic [15:0] REG_IN_POSITION_BAND = 16'h9902;
   localparam logic [15:0] REG_TRAVEL_SPEED = 16'h9904;
   localparam logic [15:0] REG_ACCEL_DECEL = 16'h9906;
   localparam int NUM_REGS = 7;
   localparam logic [2:0] IDX_TARGET = 3'h0;
   localparam logic [2:0] IDX_BAND = 3'h2;
   localparam logic [2:0] IDX_SPEED = 3'h4;
   localparam logic [2:0] IDX_ACCEL = 3'h6;
   localparam logic [3:0] REGS_FULL = 4'h7;
   localparam logic [3:0] SPEED_END = 4'h6;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Query layout: addr, func, start(2), count(2), byte count, data, check
   localparam logic [5:0] HDR_BYTES = 6'h07;
   localparam int STAGE_BYTES = 2 * NUM_REGS;
   localparam logic [5:0] LEN_SAT = 6'h3f;
   // Response: colon, six echoed bytes and check as hex, CR, LF
   localparam logic [4:0] RESP_BYTES = 5'h07;
   localparam logic [4:0] RESP_CR_POS = 5'h0f;
   localparam logic [4:0] RESP_LF_POS = 5'h10;
   // Host register map, byte addresses
   localparam logic [7:0] HREG_CTRL = 8'h00;
   localparam logic [7:0] HREG_SLAVE = 8'h04;
   localparam logic [7:0] HREG_START = 8'h08;
   localparam logic [7:0] HREG_COUNT = 8'h0c;
   localparam logic [7:0] HREG_STATUS = 8'h10;
   localparam logic [7:0] HREG_DATA0 = 8'h20;
   localparam int RESP_TIMEOUT_NS = 100000;
   localparam int RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_NS / CLK_PERIOD_NS;

   // Bit 4 flags a legal upper-case hex digit
   function automatic logic [4:0] hex_decode(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= CH_DIGIT_0 && c <= CH_DIGIT_9) begin
         r = {1'b1, c[3:0]};
      end else if (c >= CH_UPPER_A && c <= CH_UPPER_F) begin
         r = {1'b1, 4'(c[3:0] + HEX_ALPHA_ADJ)};
      end
      return r;
   endfunction

   function automatic logic [7:0] hex_encode(input logic [3:0] n);
      logic [7:0] r;
      r = (n < HEX_TEN) ? 8'(CH_DIGIT_0 + n) : 8'(CH_UPPER_A + (n - HEX_TEN));
      return r;
   endfunction
endpackage

// ---- src/mb_link_if.sv ----
/*
 Character link between the master and the motion slave.
 Assumes one shared clock; a character is valid for one cycle, no back-pressure.
*/
`timescale 1ns/1ns
interface mb_link_if;
   logic q_valid;
   logic [7:0] q_char;
   logic r_valid;
   logic [7:0] r_char;
   modport master (output q_valid, output q_char, input r_valid, input r_char);
   modport slave (input q_valid, input q_char, output r_valid, output r_char);
endinterface

// ---- src/mb_motion_master.sv ----
/*
 Master end: software loads slave address, start register, count and
 data through a small register port, then starts a query; the end sends
 the frame and checks the echoed response.
 Assumes the register port is driven synchronously to CLK by one master.
*/
`timescale 1ns/1ns
module mb_motion_master
   import mb_motion_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = RESP_TIMEOUT_CYCLES
)(
   input wire logic CLK,
   input wire logic ARST_N,
   mb_link_if.master LINK,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [31:0] RD_DATA
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_SEND = 3'b010,
      H_WAIT = 3'b100
   } master_state_type;

   master_state_type state;
   logic [7:0] slave;
   logic [15:0] start;
   logic [3:0] count;
   logic [15:0] data [NUM_REGS];
   logic done;
   logic ok;
   logic timeout;
   logic [5:0] tx_pos;
   logic [7:0] tx_sum;
   logic [15:0] wait_cnt;
   logic [3:0] rx_hi;
   logic rx_half;
   logic [3:0] rx_idx;
   logic [7:0] rx_sum;
   logic mism;
   logic go;
   logic [5:0] nbytes;
   logic [5:0] bi;
   logic [5:0] di;
   logic [7:0] tx_byte;
   logic [7:0] next_char;
   logic [4:0] rnib;
   logic [7:0] rbyte;
   logic [7:0] expect_byte;

   assign go = WR_EN && (ADDR == HREG_CTRL) && WR_DATA[0] && (state == H_IDLE);
   // Header, data bytes and the check byte
   assign nbytes = HDR_BYTES + {1'b0, count, 1'b0} + 6'h01;
   assign bi = 6'(tx_pos - 6'h01) >> 1;
   assign di = 6'(bi - HDR_BYTES);

   // Byte to send; check byte closes the byte stream
   always_comb begin
      unique case (bi)
         6'h00: tx_byte = slave;
         6'h01: tx_byte = FUNC_WRITE_MULTI;
         6'h02: tx_byte = start[15:8];
         6'h03: tx_byte = start[7:0];
         6'h04: tx_byte = 8'h00;
         6'h05: tx_byte = {4'h0, count};
         6'h06: tx_byte = {3'h0, count, 1'b0};
         default: begin
            if (bi == 6'(nbytes - 6'h01)) begin
               tx_byte = 8'(8'h00 - tx_sum);
            end else begin
               tx_byte = di[0] ? data[3'(di >> 1)][7:0] : data[3'(di >> 1)][15:8];
            end
         end
      endcase
      if (tx_pos == 6'h00) begin
         next_char = CH_COLON;
      end else if (tx_pos == 6'({nbytes, 1'b0} + 7'h01)) begin
         next_char = CH_CR;
      end else if (tx_pos == 6'({nbytes, 1'b0} + 7'h02)) begin
         next_char = CH_LF;
      end else begin
         next_char = hex_encode(tx_pos[0] ? tx_byte[7:4] : tx_byte[3:0]);
      end
   end

   // Software registers
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         slave <= AXIS_ADDR_OFFSET;
         start <= REG_TARGET_POSITION;
         count <= REGS_FULL;
      end else if (WR_EN && state == H_IDLE) begin
         if (ADDR == HREG_SLAVE) slave <= WR_DATA[7:0];
         if (ADDR == HREG_START) start <= WR_DATA[15:0];
         if (ADDR == HREG_COUNT) count <= WR_DATA[3:0];
      end
   end

   for (genvar i = 0; i < NUM_REGS; i++) begin : g_data
      always_ff @(posedge CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            data[i] <= REG_RESET;
         end else if (WR_EN && state == H_IDLE && ADDR == 8'(HREG_DATA0 + 8'(4 * i))) begin
            data[i] <= WR_DATA[15:0];
         end
      end
   end

   // Read port, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RD_DATA <= 32'h0000_0000;
      end else begin
         RD_DATA <= 32'h0000_0000;
         if (RD_EN) begin
            if (ADDR == HREG_SLAVE) RD_DATA <= {24'h0, slave};
            if (ADDR == HREG_START) RD_DATA <= {16'h0, start};
            if (ADDR == HREG_COUNT) RD_DATA <= {28'h0, count};
            if (ADDR == HREG_STATUS) RD_DATA <= {28'h0, timeout, ok, done, state != H_IDLE};
            for (int j = 0; j < NUM_REGS; j++) begin
               if (ADDR == 8'(HREG_DATA0 + 8'(4 * j))) RD_DATA <= {16'h0, data[j]};
            end
         end
      end
   end

   // Transmit sequencing and response wait
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= H_IDLE;
         tx_pos <= 6'h00;
         tx_sum <= 8'h00;
         wait_cnt <= 16'h0000;
         LINK.q_valid <= 1'b0;
         LINK.q_char <= 8'h00;
      end else begin
         LINK.q_valid <= (state == H_SEND);
         LINK.q_char <= (state == H_SEND) ? next_char : 8'h00;
         unique case (state)
            H_IDLE: begin
               tx_pos <= 6'h00;
               tx_sum <= 8'h00;
               wait_cnt <= 16'h0000;
               if (go) state <= H_SEND;
            end
            H_SEND: begin
               tx_pos <= 6'(tx_pos + 6'h01);
               // Check sum covers every byte before the check byte
               if (tx_pos != 6'h00 && !tx_pos[0]) tx_sum <= 8'(tx_sum + tx_byte);
               if (next_char == CH_LF) state <= H_WAIT;
            end
            H_WAIT: begin
               wait_cnt <= 16'(wait_cnt + 16'h0001);
               if ((LINK.r_valid && LINK.r_char == CH_LF)
                   || wait_cnt == 16'(TIMEOUT_CYCLES - 1)) state <= H_IDLE;
            end
         endcase
      end
   end

   assign rnib = hex_decode(LINK.r_char);
   assign rbyte = {rx_hi, rnib[3:0]};
   always_comb begin
      unique case (rx_idx)
         4'h0: expect_byte = slave;
         4'h1: expect_byte = FUNC_WRITE_MULTI;
         4'h2: expect_byte = start[15:8];
         4'h3: expect_byte = start[7:0];
         4'h4: expect_byte = 8'h00;
         4'h5: expect_byte = {4'h0, count};
         default: expect_byte = rbyte;
      endcase
   end

   // Response checking: echo fields, length and check value
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rx_hi <= 4'h0;
         rx_half <= 1'b0;
         rx_idx <= 4'h0;
         rx_sum <= 8'h00;
         mism <= 1'b0;
         done <= 1'b0;
         ok <= 1'b0;
         timeout <= 1'b0;
      end else if (go) begin
         done <= 1'b0;
         ok <= 1'b0;
         timeout <= 1'b0;
         rx_half <= 1'b0;
         rx_idx <= 4'h0;
         rx_sum <= 8'h00;
         mism <= 1'b0;
      end else if (state == H_WAIT) begin
         if (LINK.r_valid && LINK.r_char == CH_LF) begin
            done <= 1'b1;
            ok <= !mism && rx_idx == 4'(RESP_BYTES) && rx_sum == 8'h00 && !rx_half;
         end else if (wait_cnt == 16'(TIMEOUT_CYCLES - 1)) begin
            done <= 1'b1;
            timeout <= 1'b1;
         end else if (LINK.r_valid && LINK.r_char == CH_COLON) begin
            rx_half <= 1'b0;
            rx_idx <= 4'h0;
            rx_sum <= 8'h00;
            mism <= 1'b0;
         end else if (LINK.r_valid && rnib[4]) begin
            rx_half <= !rx_half;
            if (!rx_half) begin
               rx_hi <= rnib[3:0];
            end else begin
               rx_sum <= 8'(rx_sum + rbyte);
               rx_idx <= (rx_idx == 4'hf) ? rx_idx : 4'(rx_idx + 4'h1);
               if (rbyte != expect_byte) mism <= 1'b1;
            end
         end else if (LINK.r_valid && LINK.r_char != CH_CR) begin
            mism <= 1'b1;
         end
      end
   end
endmodule

// ---- verif/mb_motion_props.sv ----
/*
 Link checker: framing, timing and echo of the character link.
 Assumes one clock; link signals arrive as plain inputs.
*/
`timescale 1ns/1ns
module mb_motion_props
   import mb_motion_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic q_valid,
   input wire logic [7:0] q_char,
   input wire logic r_valid,
   input wire logic [7:0] r_char
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   logic [4:0] run;
   // Position within a response burst; a counter avoids long repetitions
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         run <= 5'h00;
      end else begin
         run <= r_valid ? 5'(run + 5'h01) : 5'h00;
      end
   end
   property p_q_open; $rose(q_valid) |-> q_char == CH_COLON; endproperty
   a_q_open: assert property (p_q_open) else $error("query opens badly");
   property p_q_tail; q_valid && q_char == CH_LF |-> $past(q_valid) && $past(q_char) == CH_CR;
   endproperty
   a_q_tail: assert property (p_q_tail) else $error("query tail wrong");
   property p_r_open; $rose(r_valid) |-> r_char == CH_COLON; endproperty
   a_r_open: assert property (p_r_open) else $error("response opens badly");
   property p_r_cause; $rose(r_valid) |-> $past(q_valid, 2) && $past(q_char, 2) == CH_LF;
   endproperty
   a_r_cause: assert property (p_r_cause) else $error("response not after query end");
   property p_r_len; $fell(r_valid) |-> run == 5'h11; endproperty
   a_r_len: assert property (p_r_len) else $error("response length wrong");
   property p_r_tail; $fell(r_valid) |-> $past(r_char) == CH_LF && $past(r_char, 2) == CH_CR;
   endproperty
   a_r_tail: assert property (p_r_tail) else $error("response tail wrong");
   property p_r_hex;
      r_valid && run inside {[5'h01:5'h0e]} |->
         r_char inside {[CH_DIGIT_0:CH_DIGIT_9], [CH_UPPER_A:CH_UPPER_F]};
   endproperty
   a_r_hex: assert property (p_r_hex) else $error("response char not hex");
   // Function code and the upper hex digit of the high start byte echoed
   property p_r_echo;
      r_valid && run == 5'h03 |-> r_char == 8'h31 ##1 r_char == 8'h30 ##1 r_char == 8'h39;
   endproperty
   a_r_echo: assert property (p_r_echo) else $error("response echo wrong");
endmodule

// ---- verif/tb_modbus_ascii_motion_cmd_write.sv ----
/*
 Bench: master and slave joined by the link, rows of queries, then a
 second slave fed broken frames. Assumes the checker sees the first link only.
*/
`timescale 1ns/1ns
module tb_modbus_ascii_motion_cmd_write;
   import mb_motion_pkg::*;
   // Row flags: moving, bad address, ok, move, speed update, frame error
   typedef struct packed {logic [15:0] st; logic [3:0] cnt; logic [15:0] lo; logic [5:0] f;}
      row_type;
   localparam row_type ROWS[8] = '{'{16'h9900, 4'h7, 16'h1388, 6'b001100},
      '{16'h9904, 4'h2, 16'h0fa0, 6'b101010}, '{16'h9904, 4'h2, 16'h07d0, 6'b001000},
      '{16'h9900, 4'h2, 16'h03e8, 6'b101000}, '{16'h9906, 4'h1, 16'h0bb8, 6'b001000},
      '{16'h9906, 4'h2, 16'h0000, 6'b000001}, '{16'h9900, 4'h7, 16'h1388, 6'b010000},
      '{16'h9900, 4'h0, 16'h0000, 6'b000001}};
   localparam logic [15:0] BASE[7] = '{16'h0, 16'h1388, 16'h0, 16'h000a, 16'h0, 16'h2710, 16'h1e};
   localparam string BAD[3] = '{":0110990400020400001388B2", ":0110990400020300001388B2",
      ":0110990400020400001388b1"};
   logic clk, arst_n, wr_en, rd_en, moving, mv, su, fe, fe2;
   logic [7:0] addr, axis;
   logic [31:0] wr_data, rd_data, tgt, band, spd;
   logic [15:0] acc;
   logic [15:0] m[7];
   int err_total = 0, n_compared = 0, n_mv = 0, n_su = 0, n_fe = 0, n_fe2 = 0, n_r2 = 0;
   mb_link_if u_mb_link_if();
   mb_link_if u_mb_link_if_b();
   mb_motion_master #(.TIMEOUT_CYCLES(200)) u_mb_motion_master(.CLK(clk), .ARST_N(arst_n),
      .LINK(u_mb_link_if.master), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
      .RD_EN(rd_en), .RD_DATA(rd_data));
   mb_motion_slave u_mb_motion_slave(.CLK(clk), .ARST_N(arst_n), .LINK(u_mb_link_if.slave),
      .AXIS(axis), .MOVING(moving), .TARGET_POSITION(tgt), .IN_POSITION_BAND(band),
      .TRAVEL_SPEED(spd), .ACCEL_DECEL(acc), .MOVE_START(mv), .SPEED_UPDATE(su),
      .FRAME_ERROR(fe));
   mb_motion_slave u_mb_motion_slave_b(.CLK(clk), .ARST_N(arst_n),
      .LINK(u_mb_link_if_b.slave), .AXIS(8'h00), .MOVING(1'b0), .TARGET_POSITION(),
      .IN_POSITION_BAND(), .TRAVEL_SPEED(), .ACCEL_DECEL(), .MOVE_START(), .SPEED_UPDATE(),
      .FRAME_ERROR(fe2));
   mb_motion_props u_mb_motion_props(.CLK(clk), .ARST_N(arst_n),
      .q_valid(u_mb_link_if.q_valid), .q_char(u_mb_link_if.q_char),
      .r_valid(u_mb_link_if.r_valid), .r_char(u_mb_link_if.r_char));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulse tallies; tests compare differences, or n_r2 against zero, so no clearing is needed
   always @(posedge clk) begin
      n_mv <= n_mv + 32'(mv === 1'b1);
      n_su <= n_su + 32'(su === 1'b1);
      n_fe <= n_fe + 32'(fe === 1'b1);
      n_fe2 <= n_fe2 + 32'(fe2 === 1'b1);
      n_r2 <= n_r2 + 32'(u_mb_link_if_b.r_valid === 1'b1);
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic run_row(input row_type r);
      logic [31:0] s;
      int b[3];
      b = '{n_mv, n_su, n_fe};
      // Inputs move only on a rising edge
      @(posedge clk);
      moving <= r.f[5];
      wr(HREG_SLAVE, 32'(axis + 8'h01 + 8'(r.f[4])));
      wr(HREG_START, {16'h0000, r.st});
      wr(HREG_COUNT, {28'h0, r.cnt});
      for (int k = 0; k < 7; k++) wr(HREG_DATA0 + 8'(4 * k), {16'h0, k == 1 ? r.lo : BASE[k]});
      wr(HREG_CTRL, 32'h1);
      s = 32'h0;
      for (int k = 0; k < 300 && s[1] !== 1'b1; k++) rd(HREG_STATUS, s);
      if (s[1] !== 1'b1) begin
         err_total++;
         final_report();
      end
      // Expected registers: only the written range changes
      if (r.f[3]) begin
         for (int k = 0; k < r.cnt; k++) begin
            m[r.st - REG_TARGET_POSITION + 16'(k)] = k == 1 ? r.lo : BASE[k];
         end
      end
      check("status", {29'h0, s[3:1]}, r.f[3] ? 32'h3 : 32'h5);
      check("move", n_mv - b[0], 32'(r.f[2]));
      check("speedupd", n_su - b[1], 32'(r.f[1]));
      check("fault", n_fe - b[2], 32'(r.f[0]));
      check("target", tgt, {m[0], m[1]});
      check("band", band, {m[2], m[3]});
      check("speed", spd, {m[4], m[5]});
      check("accel", {16'h0, acc}, {16'h0, m[6]});
   endtask
   initial begin
      logic [31:0] d;
      int b;
      arst_n = 1'b0;
      {wr_en, rd_en, moving, addr, wr_data} = '0;
      axis = 8'h03;
      m = '{default: 16'h0};
      u_mb_link_if_b.q_valid = 1'b0;
      u_mb_link_if_b.q_char = 8'h00;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      rd(HREG_START, d);
      check("start", d, 32'h9900);
      rd(8'h44, d);
      check("unmapped", d, 32'h0);
      check("target0", tgt, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         run_row(ROWS[i]);
         $display("row %0d done", i);
      end
      // Broken frames on the second link: no write, no answer
      for (int i = 0; i < 3; i++) begin
         b = n_fe2;
         for (int k = 0; k < BAD[i].len() + 2; k++) begin
            @(posedge clk);
            u_mb_link_if_b.q_valid <= 1'b1;
            u_mb_link_if_b.q_char <= k < BAD[i].len() ? BAD[i][k]
               : (k == BAD[i].len() ? CH_CR : CH_LF);
         end
         @(posedge clk);
         u_mb_link_if_b.q_valid <= 1'b0;
         u_mb_link_if_b.q_char <= 8'hff;
         repeat (25) @(posedge clk);
         check("badframe", n_fe2 - b, 32'h1);
      end
      check("noanswer", n_r2, 32'h0);
      $display("fault test done");
      final_report();
   end
endmodule
